/* File: logic/dsc_core.sv */
/*
  dsc_core: serial command unit for two wiper codes and a sixteen word
  nonvolatile store, with readback, write protect and preset reload.
  Assumes the host clocks data in on rising link edges, reads the
  output on rising edges, and idles the link clock low.
*/
`timescale 1ns/10ps
module dsc_core import dsc_pkg::*; (
  // clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_I,
  // serial link pins
  input  wire logic              SCLK_I,
  input  wire logic              CS_N_I,
  input  wire logic              SDI_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_O,
  // protect and preset strobe
  input  wire logic              WP_N_I,
  input  wire logic              PR_N_I,
  // wiper state
  output logic      [CODE_W-1:0] WIPER_ONE_CODE_O,
  output logic      [CODE_W-1:0] WIPER_TWO_CODE_O,
  output logic      [TAPS-1:0]   WIPER_ONE_SEL_O,
  output logic      [TAPS-1:0]   WIPER_TWO_SEL_O
);

  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [CODE_W-1:0]              wip1;
    logic [CODE_W-1:0]              wip2;
    logic [NV_DEPTH-1:0][NV_W-1:0]  nv;
    logic [FRAME_W-1:0]             rx;
    logic [FRAME_W-1:0]             tx;
    logic [FRAME_W-1:0]             last;
    logic [FRAME_W-1:0]             rb;
    logic [4:0]                     cnt;
    logic                           rb_ok;
    logic                           sclk_q;
    logic                           cs_q;
    logic                           pr_q;
    logic                           reload;
    logic                           sdo;
    logic                           oe;
  } dsc_core_s;

  dsc_core_s st_reg;
  dsc_core_s st_next;

  dsc_pin_if pin ();

  logic               sclk_rise;
  logic               sclk_fall;
  logic               cs_fall;
  logic               cs_rise;
  logic               pr_fall;
  logic               exec_now;
  logic [FRAME_W-1:0] fr;
  logic [FRAME_W-1:0] ld_word;
  logic [3:0]         cmd;
  logic [3:0]         addr;
  logic [NV_W-1:0]    data;
  logic [CODE_W-1:0]  fr_code;
  logic [NV_W-1:0]    nv_at;
  logic               ld_msb;

  // ********************
  // pins
  // ********************
  dsc_sync u_sync (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .pins_i ({PR_N_I, WP_N_I, CS_N_I, SDI_I, SCLK_I}),
    .pin    (pin.src)
  );

  // edges of the filtered levels
  assign sclk_rise = pin.sclk && !st_reg.sclk_q;
  assign sclk_fall = !pin.sclk && st_reg.sclk_q;
  assign cs_fall   = !pin.cs_n && st_reg.cs_q;
  assign cs_rise   = pin.cs_n && !st_reg.cs_q;
  assign pr_fall   = !pin.pr_n && st_reg.pr_q;

  // a full frame runs, an empty strobe reruns the last one
  assign exec_now = cs_rise && (st_reg.cnt == FRAME_BITS || st_reg.cnt == 5'h00);
  assign fr       = (st_reg.cnt == 5'h00) ? st_reg.last : st_reg.rx;

  // field split: command, address, data
  assign cmd     = fr[CMD_MSB -: 4];
  assign addr    = fr[ADDR_MSB -: 4];
  assign data    = fr[NV_W-1:0];
  assign fr_code = fr[CODE_W-1:0];
  assign nv_at   = st_reg.nv[addr];

  // readback replaces the echo of the previous frame
  assign ld_word = st_reg.rb_ok ? st_reg.rb : st_reg.last;
  assign ld_msb  = ld_word[FRAME_W-1];

  // ********************
  // next state
  // ********************
  always_comb begin
    logic [CODE_W-1:0] cur;
    logic [CODE_W-1:0] w;
    logic              wr;
    logic              ch2;
    logic              chok;
    cur            = CODE_ZERO;
    w              = CODE_ZERO;
    wr             = 1'b0;
    ch2            = (addr == ADDR_CH2);
    chok           = (addr == ADDR_CH1) || ch2;
    st_next        = st_reg;
    st_next.sclk_q = pin.sclk;
    st_next.cs_q   = pin.cs_n;
    st_next.pr_q   = pin.pr_n;
    st_next.oe     = !pin.cs_n;
    st_next.reload = 1'b0;

    // power-on pass and preset strobe both reload the wipers
    if (st_reg.reload || pr_fall) begin
      st_next.wip1 = st_reg.nv[ADDR_CH1][CODE_W-1:0];
      st_next.wip2 = st_reg.nv[ADDR_CH2][CODE_W-1:0];
    end

    // link shifting: in on rising edges, out on falling edges
    if (cs_fall) begin
      st_next.cnt   = 5'h00;
      st_next.tx    = ld_word;
      st_next.sdo   = ld_msb;
      st_next.rb_ok = 1'b0;
    end else if (!pin.cs_n && sclk_rise) begin
      st_next.rx = {st_reg.rx[FRAME_W-2:0], pin.sdi};
      if (st_reg.cnt != CNT_MAX) begin
        st_next.cnt = st_reg.cnt + 5'h01;
      end
    end else if (!pin.cs_n && sclk_fall) begin
      st_next.tx  = {st_reg.tx[FRAME_W-2:0], 1'b0};
      st_next.sdo = st_reg.tx[FRAME_W-2];
    end

    // ********************
    // command execution
    // ********************
    cur = ch2 ? st_reg.wip2 : st_reg.wip1;
    if (exec_now) begin
      st_next.last  = fr;
      st_next.rb_ok = 1'b0;
      unique case (cmd)
        CMD_NOP: begin
          wr = 1'b0;
        end
        CMD_RESTORE: begin
          w  = nv_at[CODE_W-1:0];
          wr = chok;
        end
        CMD_SAVE: begin
          // protect low refuses every store write
          if (chok && pin.wp_n) begin
            st_next.nv[addr] = {{(NV_W-CODE_W){1'b0}}, cur};
          end
        end
        CMD_USER: begin
          // tolerance word and saved wipers are out of reach here
          if (addr >= ADDR_USR_LO && addr <= ADDR_USR_HI && pin.wp_n) begin
            st_next.nv[addr] = data;
          end
        end
        CMD_RD_NV: begin
          st_next.rb_ok = 1'b1;
          st_next.rb    = {fr[CMD_MSB -: 8], nv_at};
        end
        CMD_RD_WIP: begin
          st_next.rb_ok = chok;
          st_next.rb    = {fr[CMD_MSB -: 8], {(NV_W-CODE_W){1'b0}}, cur};
        end
        CMD_WRITE: begin
          w  = fr_code;
          wr = chok;
        end
        CMD_SHL: begin
          w  = shl_code(cur);
          wr = chok;
        end
        CMD_INC: begin
          w  = inc_code(cur);
          wr = chok;
        end
        default: begin
          wr = 1'b0; // unsupported codes are ignored
        end
      endcase
      if (wr && ch2) begin
        st_next.wip2 = w;
      end else if (wr) begin
        st_next.wip1 = w;
      end
    end
  end

  // ********************
  // registers
  // ********************
  // store seeded at reset, then wipers reloaded from it one cycle later
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      st_reg           <= '0;
      // word 0 sits at the right end of the packed store
      st_reg.nv        <= {TOL_INIT, {(NV_DEPTH-1){NV_INIT}}};
      st_reg.nv[ADDR_TOL] <= TOL_INIT;
      st_reg.wip1      <= CODE_ZERO;
      st_reg.wip2      <= CODE_ZERO;
      st_reg.sclk_q    <= 1'b0;
      st_reg.cs_q      <= 1'b1;
      st_reg.pr_q      <= 1'b1;
      st_reg.reload    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************
  // outputs
  // ********************
  assign SDO_O            = st_reg.sdo;
  assign SDO_OE_O         = st_reg.oe;
  assign WIPER_ONE_CODE_O = st_reg.wip1;
  assign WIPER_TWO_CODE_O = st_reg.wip2;

  // tap decoders, one per channel
  dsc_tap_dec u_dec1 (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .code_i (st_reg.wip1),
    .sel_o  (WIPER_ONE_SEL_O)
  );

  dsc_tap_dec u_dec2 (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .code_i (st_reg.wip2),
    .sel_o  (WIPER_TWO_SEL_O)
  );

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence run_s(logic [7:0] op);
    exec_now && fr[CMD_MSB -: 8] == op;
  endsequence

  sequence empty_s;
    cs_rise && st_reg.cnt == 5'h00;
  endsequence

  write_one_a: assert property (run_s(8'hb0) |=> st_reg.wip1 == $past(fr_code))
    else $error("direct write missed channel one");
  write_two_a: assert property (run_s(8'hb1) |=> st_reg.wip2 == $past(fr_code))
    else $error("direct write missed channel two");
  nop_keep_a: assert property (run_s(8'h00) ##0 !pr_fall
    |=> $stable(st_reg.wip1) && $stable(st_reg.wip2) && $stable(st_reg.nv))
    else $error("no-op changed state");
  inc_step_a: assert property (run_s(8'he0) ##0 st_reg.wip1 != CODE_FULL
    |=> st_reg.wip1 == $past(st_reg.wip1) + CODE_ONE)
    else $error("increment not by one");
  dbl_full_a: assert property (run_s(8'hc0) ##0 st_reg.wip1 >= CODE_MID
    |=> st_reg.wip1 == CODE_FULL)
    else $error("doubling overflowed");
  dbl_zero_a: assert property (run_s(8'hc0) ##0 st_reg.wip1 == CODE_ZERO
    |=> st_reg.wip1 == CODE_ONE)
    else $error("doubling zero not one");
  wp_lock_a: assert property (exec_now && !pin.wp_n |=> $stable(st_reg.nv))
    else $error("store written under protect");
  tol_ro_a: assert property ($stable(st_reg.nv[ADDR_TOL]))
    else $error("tolerance word changed");
  rd_word_a: assert property (exec_now && cmd == CMD_RD_NV
    |=> st_reg.rb_ok && st_reg.rb[NV_W-1:0] == $past(nv_at))
    else $error("store readback wrong");
  rd_wip_a: assert property (run_s(8'ha0)
    |=> st_reg.rb == {8'ha0, 6'h00, $past(st_reg.wip1)})
    else $error("wiper readback wrong");
  rerun_a: assert property (empty_s ##0 (st_reg.last[CMD_MSB -: 8] == 8'he0
    && st_reg.wip1 != CODE_FULL) |=> st_reg.wip1 == $past(st_reg.wip1) + CODE_ONE)
    else $error("empty strobe did not rerun");
  out_first_a: assert property (cs_fall |=> SDO_O == $past(ld_msb) && SDO_OE_O)
    else $error("frame output msb wrong");
endmodule // dsc_core

/* File: logic/dsc_pin_if.sv */
/*
  dsc_pin_if: filtered pin levels passed from the synchroniser to
  the command core. Assumes both ends run on the core clock.
*/
`timescale 1ns/10ps
interface dsc_pin_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic wp_n;
  logic pr_n;
  modport src (output sclk, cs_n, sdi, wp_n, pr_n);
  modport dst (input  sclk, cs_n, sdi, wp_n, pr_n);
endinterface // dsc_pin_if

/* File: logic/dsc_pkg.sv */
/*
  dsc_pkg: frame layout, command codes, store map, reset values and
  wiper arithmetic for the dual wiper serial command unit.
  Assumes one core clock; every pin is sampled through dsc_sync.
*/
// What this block does
// - each channel holds a 10-bit code decoded to one of 1024 taps
// - code zero is the bottom tap, each step up moves one tap up
// - user store words are 16 bits, written by store-user, read by read-store
// - command 0xB address 0 loads low data bits into channel one wiper
// - command 0xB address 1 loads low data bits into channel two wiper
// - command 0 changes nothing yet a full 24-bit word still shifts out
// - after read-store, the next frame returns the word in its last 16 bits
// - command 0xE address 0 adds exactly one to channel one below full scale, held at full scale, data ignored
// - command 0x2 copies the addressed wiper into its saved store word
// - store writes are refused while write-protect is low
// - wipers reload from saved words at power-on, preset strobe, restore command
// - command 0x1 address 0 copies saved word one into channel one
// - command 0xC doubles the addressed wiper by a left shift
// - doubling at or above midscale gives full scale, no overflow
// - command 0x3 writes 16 data bits into the addressed user word
// - after read-wiper, the next frame returns command byte then wiper code
// - the tolerance word at address 15 can never be written
// - doubling a zero code gives code one
// - addresses 0,1 saved wipers, 2 to 14 user words, 15 tolerance
// - a select pulse with no clock edges repeats the previous command
package dsc_pkg;

  // ********************
  // frame layout
  // ********************
  localparam int         FRAME_W    = 32'h18;
  localparam int         CODE_W     = 32'ha;
  localparam int         NV_W       = 32'h10;
  localparam int         NV_DEPTH   = 32'h10;
  localparam int         TAPS       = 32'h400;
  localparam int         CMD_MSB    = 32'h17;
  localparam int         ADDR_MSB   = 32'h13;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] CNT_MAX    = 5'h1f;

  // ********************
  // commands and addresses
  // ********************
  localparam logic [3:0] CMD_NOP     = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_SAVE    = 4'h2;
  localparam logic [3:0] CMD_USER    = 4'h3;
  localparam logic [3:0] CMD_RD_NV   = 4'h9;
  localparam logic [3:0] CMD_RD_WIP  = 4'ha;
  localparam logic [3:0] CMD_WRITE   = 4'hb;
  localparam logic [3:0] CMD_SHL     = 4'hc;
  localparam logic [3:0] CMD_INC     = 4'he;
  localparam logic [3:0] ADDR_CH1    = 4'h0;
  localparam logic [3:0] ADDR_CH2    = 4'h1;
  localparam logic [3:0] ADDR_USR_LO = 4'h2;
  localparam logic [3:0] ADDR_USR_HI = 4'he;
  localparam logic [3:0] ADDR_TOL    = 4'hf;

  // ********************
  // codes and reset values
  // ********************
  localparam logic [9:0]  CODE_ZERO = 10'h000;
  localparam logic [9:0]  CODE_ONE  = 10'h001;
  localparam logic [9:0]  CODE_MID  = 10'h200;
  localparam logic [9:0]  CODE_FULL = 10'h3ff;
  localparam logic [15:0] NV_INIT   = 16'h0200;
  localparam logic [15:0] TOL_INIT  = 16'h0000;
  // idle pin levels {pr_n, wp_n, cs_n, sdi, sclk}
  localparam logic [4:0]  PIN_IDLE  = 5'h1c;

  // doubling with both corner fixes
  function automatic logic [9:0] shl_code(input logic [9:0] c);
    if (c == CODE_ZERO) begin
      return CODE_ONE;
    end
    if (c >= CODE_MID) begin
      return CODE_FULL;
    end
    return {c[8:0], 1'b0};
  endfunction

  // single step, held at full scale
  function automatic logic [9:0] inc_code(input logic [9:0] c);
    return (c == CODE_FULL) ? c : c + CODE_ONE;
  endfunction

endpackage

/* File: logic/dsc_sync.sv */
/*
  dsc_sync: three-stage synchroniser with agreement filter for the
  five serial pins. Assumes pins are asynchronous to the core clock.
*/
`timescale 1ns/10ps
module dsc_sync import dsc_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // raw pins {pr_n, wp_n, cs_n, sdi, sclk}
  input  wire logic [4:0] pins_i,
  // filtered levels
  dsc_pin_if.src          pin
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
  } dsc_sync_s;

  dsc_sync_s st_reg;
  dsc_sync_s st_next;

  // a level moves only once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pins_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < 5; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  // idle levels at reset so no false edge follows release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= {PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin.sclk = st_reg.lvl[0];
  assign pin.sdi  = st_reg.lvl[1];
  assign pin.cs_n = st_reg.lvl[2];
  assign pin.wp_n = st_reg.lvl[3];
  assign pin.pr_n = st_reg.lvl[4];
endmodule // dsc_sync

/* File: logic/dsc_tap_dec.sv */
/*
  dsc_tap_dec: registered one-hot decode of a wiper code to a ladder
  tap select. Assumes the code comes from logic on the same clock.
*/
`timescale 1ns/10ps
module dsc_tap_dec import dsc_pkg::*; (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wiper code in, tap select out
  input  wire logic [CODE_W-1:0] code_i,
  output logic      [TAPS-1:0]   sel_o
);
  typedef struct packed {
    logic [TAPS-1:0] sel;
  } dsc_dec_s;

  dsc_dec_s st_reg;
  dsc_dec_s st_next;

  // exactly one tap on, tap index equals code
  always_comb begin
    st_next             = '{sel: '0};
    st_next.sel[code_i] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{sel: {{(TAPS-1){1'b0}}, 1'b1}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sel_o = st_reg.sel;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  one_tap_a: assert property ($onehot(st_reg.sel))
    else $error("tap select not one-hot");
  tap_order_a: assert property (##1 st_reg.sel[$past(code_i)])
    else $error("selected tap does not follow code");
endmodule // dsc_tap_dec

/* File: verif/dsc_core_tb.sv */
/*
  dsc_core_tb: self-checking bench for the serial command unit.
  Assumes dsc_host_model as link master and idle pins during reset.
*/
`timescale 1ns/10ps
module dsc_core_tb import dsc_pkg::*; ;
  // ********************
  // signals
  // ********************
  logic              core_clk;
  logic              rst;
  logic              sclk;
  logic              cs_n;
  logic              sdi;
  logic              sdo;
  logic              sdo_oe;
  logic              wp_n;
  logic              pr_n;
  logic [CODE_W-1:0] code1;
  logic [CODE_W-1:0] code2;
  logic [TAPS-1:0]   sel1;
  logic [TAPS-1:0]   sel2;
  logic [23:0]       rx;
  int                failures;
  int                cmp_count;

  // ********************
  // instances
  // ********************
  dsc_core i_dut (
    .CORE_CLK_I(core_clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .WP_N_I(wp_n),
    .PR_N_I(pr_n), .WIPER_ONE_CODE_O(code1), .WIPER_TWO_CODE_O(code2),
    .WIPER_ONE_SEL_O(sel1), .WIPER_TWO_SEL_O(sel2)
  );
  dsc_host_model i_host (
    .clk_i(core_clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo)
  );

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic xfer(input logic [23:0] tx);
    i_host.frame(tx, rx);
  endtask

  // both codes, plus one-hot tap select matching each code
  task automatic codes(input logic [9:0] e1, input logic [9:0] e2);
    check({14'h0, code1}, {14'h0, e1}, "channel one code");
    check({14'h0, code2}, {14'h0, e2}, "channel two code");
    check({23'h0, sel1 === (TAPS'(1) << e1)}, 24'h1, "tap select one");
    check({23'h0, sel2 === (TAPS'(1) << e2)}, 24'h1, "tap select two");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_write();
    codes(CODE_MID, CODE_MID);
    xfer(24'hb00100);
    xfer(24'hb10000);
    check(rx, 24'hb00100, "echo of previous frame");
    codes(10'h100, CODE_ZERO);
    xfer(24'hb10200);
    codes(10'h100, CODE_MID);
    $display("test write done");
  endtask

  // step twice, then a bare select strobe repeats the step
  task automatic t_step();
    xfer(24'he0ffff);
    xfer(24'he0ffff);
    check(rx, 24'he0ffff, "echo of step frame");
    codes(10'h102, CODE_MID);
    check({23'h0, sdo_oe}, 24'h0, "output enable idle");
    // enable must rise while the bare strobe holds select low
    fork
      i_host.pulse();
      begin
        repeat (7) @(posedge core_clk);
        check({23'h0, sdo_oe}, 24'h1, "output enable in frame");
      end
    join
    codes(10'h103, CODE_MID);
    $display("test step done");
  endtask

  // doubling corners, then wiper readback of both channels
  task automatic t_double();
    xfer(24'hb00000);
    xfer(24'hc00000);
    codes(CODE_ONE, CODE_MID);
    xfer(24'hb00200);
    xfer(24'hc01234);
    codes(CODE_FULL, CODE_MID);
    xfer(24'hb10000);
    xfer(24'hc1ffff);
    codes(CODE_FULL, CODE_ONE);
    xfer(24'hb10005);
    xfer(24'hc1abcd);
    codes(CODE_FULL, 10'h00a);
    xfer(24'ha05555);
    xfer(24'h000000);
    check(rx, 24'ha003ff, "wiper one readback");
    codes(CODE_FULL, 10'h00a);
    xfer(24'ha1aaaa);
    xfer(24'h001234);
    check(rx, 24'ha1000a, "wiper two readback");
    $display("test double done");
  endtask

  // user words, tolerance word write attempt, readback by table
  task automatic t_user();
    logic [3:0]  adr [5];
    logic [15:0] val [5];
    int          k;
    adr = '{4'h2, 4'h3, 4'he, ADDR_TOL, ADDR_CH2};
    val = '{16'haaaa, 16'h5555, 16'h0f0f, TOL_INIT, NV_INIT};
    xfer(24'h32aaaa);
    xfer(24'h335555);
    xfer(24'h3e0f0f);
    xfer(24'h3f1234);
    for (k = 0; k < 5; k++) begin
      xfer({CMD_RD_NV, adr[k], 16'hc3c3});
      xfer(24'h000000);
      check(rx, {CMD_RD_NV, adr[k], val[k]}, "store readback");
    end
    $display("test user done");
  endtask

  // save and restore, then the same with write protect low
  task automatic t_save();
    xfer(24'hb00123);
    xfer(24'h20ffff);
    xfer(24'hb00050);
    xfer(24'h10abcd);
    check({14'h0, code1}, 24'h000123, "restored code");
    @(posedge core_clk);
    wp_n <= 1'b0;
    xfer(24'hb000aa);
    xfer(24'h200000);
    xfer(24'h324321);
    xfer(24'h100000);
    check({14'h0, code1}, 24'h000123, "protected restore");
    xfer(24'h920000);
    xfer(24'h000000);
    check(rx, 24'h92aaaa, "protected user word");
    @(posedge core_clk);
    wp_n <= 1'b1;
    $display("test save done");
  endtask

  // preset strobe reloads both channels from saved words
  task automatic t_preset();
    xfer(24'hb00001);
    xfer(24'hb10002);
    @(posedge core_clk);
    pr_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    pr_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    codes(10'h123, CODE_MID);
    $display("test preset done");
  endtask

  // ********************
  // main sequence and watchdog
  // ********************
  initial begin
    failures  = 0;
    cmp_count = 0;
    rst       = 1'b1;
    wp_n      = 1'b1;
    pr_n      = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    t_write();
    t_step();
    t_double();
    t_user();
    t_save();
    t_preset();
    finish_test();
  end

  // whole run is near 9000 cycles; allow a wide margin
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    finish_test();
  end

endmodule // dsc_core_tb

/* File: verif/dsc_host_model.sv */
/*
  dsc_host_model: host side of the serial link; sends 24-bit frames msb
  first and gathers the echo word from the serial output.
  Assumes the unit samples on rising link edges, shifts out on falling
  edges, and that the core clock paces this model at 4 cycles per half bit.
*/
`timescale 1ns/10ps
module dsc_host_model (
  // core clock for pacing
  input  wire logic clk_i,
  // link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // ********************
  // idle levels
  // ********************
  // link clock stands low outside frames, select idles high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // ********************
  // frame transfer
  // ********************
  // 80 ns link period; echo sampled late in the high phase because the
  // unit's synchroniser moves its output some cycles after our falling edge
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    int i;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    sdi_o  <= tx[23];
    repeat (8) @(posedge clk_i);
    for (i = 23; i >= 0; i--) begin
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rx[i] = sdo_i;
      sclk_o <= 1'b0;
      // released data line shows the inverse, never a stale bit
      if (i > 0) begin
        sdi_o <= tx[i-1];
      end else begin
        sdi_o <= ~tx[0];
      end
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask

  // select strobe with no clock and no data
  task automatic pulse();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask

endmodule // dsc_host_model
